// ---- verilog/adcc_pkg.sv ----
/*
  Constants for the converter control block: register offsets, field positions,
  reset values and conversion timing.
  Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package adcc_pkg;
  localparam int ADDR_W = 16;
  // Register indices; byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_RESULT_HIGH = 16'hffc4;
  localparam logic [ADDR_W-1:0] IDX_RESULT_LOW = 16'hffc5;
  localparam logic [ADDR_W-1:0] IDX_MODE = 16'hffc6;
  localparam logic [ADDR_W-1:0] IDX_START = 16'hffc7;
  localparam logic [ADDR_W-1:0] IDX_PORT_B_FUNC = 16'hffee;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 16'hfff0;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 16'hfff1;
  localparam int BUS_ADDR_W = ADDR_W + 2;

  localparam int SPEED_BIT = 7;
  localparam int START_BIT = 7;
  localparam int SHARED_PIN_BIT = 3;
  localparam int RES_W = 10;
  localparam int LOW_RES_POS = 6;
  localparam int N_CHAN = 8;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [7:0] PORT_B_RESET = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;

  localparam int CLK_MHZ = 50;
  // Conversion time in nanoseconds for each speed setting.
  localparam int CONV_FAST_NS = 12400;
  localparam int CONV_SLOW_NS = 24800;
  localparam int CONV_FAST_CYC = CONV_FAST_NS * CLK_MHZ / 1000;
  localparam int CONV_SLOW_CYC = CONV_SLOW_NS * CLK_MHZ / 1000;
  localparam int CNT_W = 11;
endpackage

// ---- verilog/adcc_sar.sv ----
/*
  Successive approximation engine: one result bit per step, from the top bit down,
  with each step lasting the given step_cycles count, so the whole conversion takes RES_W steps.
  Assumes the comparator input comes from the analog front end, already synchronised.
*/
`timescale 1ns/100ps
module adcc_sar
  import adcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [CNT_W-1:0] step_cycles,
  input wire logic comp_above,
  output logic [RES_W-1:0] dac_code,
  output logic busy,
  output logic done,
  output logic [RES_W-1:0] result
);
  logic [CNT_W-1:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [RES_W-1:0] trial_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      bit_reg <= '0;
      trial_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        cnt_reg <= step_cycles;
        bit_reg <= 4'(RES_W - 1);
        trial_reg <= 10'h200;
      end else if (busy) begin
        if (cnt_reg > 1) begin
          cnt_reg <= cnt_reg - 1'b1;
        end else begin
          cnt_reg <= step_cycles;
          // Keep the trial bit only when the input stands above the trial level.
          if (!comp_above) begin
            trial_reg[bit_reg] <= 1'b0;
          end
          if (bit_reg == 0) begin
            busy <= 1'b0;
            done <= 1'b1;
            result <= comp_above ? trial_reg : (trial_reg & ~10'h001);
          end else begin
            bit_reg <= bit_reg - 1'b1;
            trial_reg[bit_reg - 1'b1] <= 1'b1;
          end
        end
      end
    end
  end

  assign dac_code = trial_reg;
endmodule

// ---- verilog/adcc_top.sv ----
/*
  Converter control block: mode, start, result and port function registers on an
  Avalon-MM slave, channel selection, conversion sequencing and an interrupt.
  Assumes an analog front end with a mux select, a trial-level DAC and a comparator.
*/
`timescale 1ns/100ps
module adcc_top
  import adcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [adcc_pkg::BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comp_above_pin,
  output logic [2:0] analog_mux_sel,
  output logic analog_mux_en,
  output logic [adcc_pkg::RES_W-1:0] dac_code,
  output logic shared_pin_interrupt_select,
  output logic irq
);
  import adcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  logic [ADDR_W-1:0] idx;
  logic wr_en;
  logic rd_en;
  logic rd_done_reg;
  logic lane0;

  assign idx = avs_address[BUS_ADDR_W-1:2];
  assign lane0 = avs_byteenable[0];
  assign wr_en = avs_write && lane0;
  // Writes finish at once; reads wait one cycle for registered data.
  assign rd_en = avs_read && !rd_done_reg;
  assign avs_waitrequest = avs_read && !rd_done_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0] mode_reg;
  logic start_flag_reg;
  logic [7:0] port_b_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [RES_W-1:0] result_reg;

  logic speed_select;
  logic channel_sel_bit3;
  logic channel_sel_bit2;
  logic channel_sel_bit1;
  logic channel_sel_bit0;
  logic chan_valid;
  logic [2:0] chan_num;

  assign speed_select = mode_reg[SPEED_BIT];
  assign channel_sel_bit3 = mode_reg[3];
  assign channel_sel_bit2 = mode_reg[2];
  assign channel_sel_bit1 = mode_reg[1];
  assign channel_sel_bit0 = mode_reg[0];

  // Pattern 01xx picks channels 0 to 3, 1xxx picks channels 4 to 7.
  always_comb begin
    chan_valid = 1'b0;
    chan_num = 3'h0;
    if (channel_sel_bit3) begin
      chan_valid = 1'b1;
      chan_num = {1'b1, channel_sel_bit1, channel_sel_bit0};
    end else if (channel_sel_bit2) begin
      chan_valid = 1'b1;
      chan_num = {1'b0, channel_sel_bit1, channel_sel_bit0};
    end
  end

  logic start_req;
  logic stop_req;
  logic conv_busy;
  logic conv_done;
  logic [RES_W-1:0] conv_result;
  logic [CNT_W-1:0] step_cycles;

  assign start_req = wr_en && idx == IDX_START && avs_writedata[START_BIT] && !start_flag_reg;
  assign stop_req = wr_en && idx == IDX_START && !avs_writedata[START_BIT] && start_flag_reg;
  assign step_cycles = speed_select ? CNT_W'(CONV_SLOW_CYC / RES_W)
                                    : CNT_W'(CONV_FAST_CYC / RES_W);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
    end else if (wr_en && idx == IDX_MODE) begin
      mode_reg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_b_reg <= PORT_B_RESET;
    end else if (wr_en && idx == IDX_PORT_B_FUNC) begin
      port_b_reg <= avs_writedata[7:0];
    end
  end

  assign shared_pin_interrupt_select = port_b_reg[SHARED_PIN_BIT];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_flag_reg <= START_RESET[START_BIT];
    end else if (start_req) begin
      start_flag_reg <= 1'b1;
    end else if (stop_req || conv_done) begin
      start_flag_reg <= 1'b0;
    end
  end

  // The result lands in the same edge that drops the flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result_reg <= '0;
    end else if (conv_done) begin
      result_reg <= conv_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.
  logic [1:0] irq_events;
  logic [1:0] irq_clear;

  assign irq_events = {stop_req, conv_done};
  assign irq_clear = (wr_en && idx == IDX_IRQ_STATUS) ? avs_writedata[1:0] : 2'h0;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      // A new event wins over a clear in the same cycle.
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (wr_en && idx == IDX_IRQ_MASK) begin
      irq_mask_reg <= avs_writedata[1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser and conversion engine.
  logic comp_meta_reg;
  logic comp_sync_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_above_pin;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  adcc_sar u_sar (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(start_req),
    .abort(stop_req),
    .step_cycles(step_cycles),
    .comp_above(comp_sync_reg),
    .dac_code(dac_code),
    .busy(conv_busy),
    .done(conv_done),
    .result(conv_result)
  );

  // The mux is latched at start so a mode write mid-conversion cannot move it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_mux_sel <= 3'h0;
      analog_mux_en <= 1'b0;
    end else if (start_req) begin
      analog_mux_sel <= chan_num;
      analog_mux_en <= chan_valid;
    end else if (!conv_busy) begin
      analog_mux_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      IDX_RESULT_HIGH: rd_byte = result_reg[RES_W-1:RES_W-8];
      IDX_RESULT_LOW: rd_byte = {result_reg[1:0], 6'h00};
      IDX_MODE: rd_byte = mode_reg;
      IDX_START: rd_byte = {start_flag_reg, 7'h00};
      IDX_PORT_B_FUNC: rd_byte = port_b_reg;
      IDX_IRQ_STATUS: rd_byte = {6'h00, irq_status_reg};
      IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // Result bytes have no write path, so writes to them are dropped.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_done_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done_reg <= rd_en;
      if (rd_en) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end
endmodule

// ---- dv/adcc_chk_sva.sv ----
/* Port checker for adcc_top.
   Assumes it is bound to every adcc_top instance. */
`timescale 1ns/100ps
module adcc_chk
  import adcc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] analog_mux_sel,
  input wire logic analog_mux_en,
  input wire logic [9:0] dac_code,
  input wire logic shared_pin_interrupt_select,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic [15:0] ix = avs_address[17:2];
  wire logic wr = avs_write && avs_byteenable[0];
  logic [7:0] mode_sh;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_sh <= 8'h00;
    end else if (wr && ix == IDX_MODE) begin
      mode_sh <= avs_writedata[7:0];
    end
  end
  ////////////////////////////////
  property p_wr_nowait; avs_write |-> !avs_waitrequest; endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  property p_rd_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait state wrong");
  property p_rd_top; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_rd_top: assert property (p_rd_top)
    else $error("read data upper bits set");
  property p_unmap; avs_read && !avs_waitrequest && ix == 16'h0100 |-> avs_readdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  property p_pin; wr && ix == IDX_PORT_B_FUNC |=>
    shared_pin_interrupt_select == $past(avs_writedata[3]); endproperty
  a_pin: assert property (p_pin)
    else $error("shared pin select wrong");
  property p_trial; wr && ix == IDX_START && avs_writedata[7] |-> ##[1:3] dac_code == 10'h200;
  endproperty
  a_trial: assert property (p_trial)
    else $error("conversion did not start");
  property p_chan; $rose(analog_mux_en) |->
    analog_mux_sel == {mode_sh[3], mode_sh[1:0]} && (mode_sh[3] || mode_sh[2]); endproperty
  a_chan: assert property (p_chan)
    else $error("channel select wrong");
  property p_irq_clr; wr && ix == IDX_IRQ_STATUS && avs_writedata[1:0] == 2'h3 |=> !irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq stays after clear");
  property p_irq_mask; wr && ix == IDX_IRQ_MASK && avs_writedata[1:0] == 2'h0 |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq stays when masked");
endmodule
bind adcc_top adcc_chk u_chk (.*);

// ---- dv/tb.sv ----
/* Self-checking bench for adcc_top with a comparator model.
   Assumes the package, the design and the checker are compiled first. */
`timescale 1ns/100ps
module tb;
  import adcc_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, comp_above_pin = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, analog_mux_en, shared_pin_interrupt_select, irq;
  logic [2:0] analog_mux_sel;
  logic [9:0] dac_code, vin = 10'h0;
  logic [15:0] sd = 16'h004b;
  logic [7:0] md;
  int err_count = 0, cmp_count = 0, cyc = 0, t0, c;
  adcc_top uut (.*);
  initial forever #10 sys_clk = ~sys_clk;
  // Comparator model: input sits half a step above vin.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    comp_above_pin <= (dac_code <= vin);
  end
  ////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int n = 0;
    avs_address <= {ix, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    // The request stands until the rising edge at which waitrequest is seen low.
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 8'h00);
    chk(q, e);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Tests need about 6000 cycles; the watchdog allows seven times that.
  initial begin
    repeat (42000) @(posedge sys_clk);
    err_count++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(IDX_MODE, 32'h0);
    rd(IDX_START, 32'h0);
    rd(IDX_PORT_B_FUNC, 32'h0);
    rd(IDX_IRQ_MASK, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      sd = lfsr(sd);
      md = {sd[15:12], i[0], sd[10:8]};
      wr(IDX_PORT_B_FUNC, md);
      rd(IDX_PORT_B_FUNC, {24'h0, md});
      chkp(shared_pin_interrupt_select, i[0]);
      md = sd[7:0];
      wr(IDX_MODE, md);
      rd(IDX_MODE, {24'h0, md});
    end
    avs_byteenable <= 4'h0;
    wr(IDX_MODE, ~md);
    avs_byteenable <= 4'h1;
    rd(IDX_MODE, {24'h0, md});
    wr(16'h0100, 8'hff);
    rd(16'h0100, 32'h0);
    wr(IDX_RESULT_HIGH, 8'hff);
    rd(IDX_RESULT_HIGH, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      sd = lfsr(sd);
      vin <= sd[9:0];
      md = (i == 7) ? 8'h8b : 8'h04 + 8'(i);
      c = md[7] ? 1240 : 620;
      wr(IDX_MODE, md);
      wr(IDX_IRQ_MASK, 8'h01);
      wr(IDX_START, 8'h80);
      t0 = cyc;
      rd(IDX_START, 32'h80);
      chkp(analog_mux_en, 1'b1);
      chk({29'h0, analog_mux_sel}, i);
      do bus(1'b0, IDX_START, 8'h00); while (q[7] === 1'b1 && cyc - t0 < 3000);
      chkp(q[7], 1'b0);
      chkp(cyc - t0 > c - 8 && cyc - t0 < c + 12, 1'b1);
      rd(IDX_RESULT_HIGH, {24'h0, sd[9:2]});
      rd(IDX_RESULT_LOW, {24'h0, sd[1:0], 6'h0});
      rd(IDX_IRQ_STATUS, 32'h1);
      chkp(irq, 1'b1);
      wr(IDX_IRQ_MASK, 8'h00);
      chkp(irq, 1'b0);
      wr(IDX_IRQ_MASK, 8'h01);
      chkp(irq, 1'b1);
      wr(IDX_IRQ_STATUS, 8'h03);
      chkp(irq, 1'b0);
    end
    $display("test conversions done");
    vin <= ~sd[9:0];
    wr(IDX_MODE, 8'h30);
    wr(IDX_START, 8'h80);
    chkp(analog_mux_en, 1'b0);
    repeat (100) @(posedge sys_clk);
    wr(IDX_START, 8'h00);
    rd(IDX_START, 32'h0);
    rd(IDX_IRQ_STATUS, 32'h2);
    rd(IDX_RESULT_HIGH, {24'h0, sd[9:2]});
    $display("test abort done");
    final_report;
  end
endmodule
